/* fcap_pkg.sv */
// package with register map, field layout and reset values for fcap block
package fcap_pkg;
	localparam logic [11:0] OFS_TARGET_ADDR  = 12'h028;
	localparam logic [11:0] OFS_WRITE_WORD   = 12'h02c;
	localparam logic [11:0] OFS_FUSE_BITS    = 12'h030;
	localparam logic [11:0] OFS_TIMEOUT_OPTS = 12'h034;
	localparam logic [11:0] OFS_CLK_DEFAULTS = 12'h038;
	localparam logic [11:0] OFS_PROG_TIMING  = 12'h03c;
	localparam logic [11:0] OFS_ERASE_TIMING = 12'h040;
	localparam logic [11:0] OFS_IDENT_FOUR   = 12'hfd0;
	localparam logic [11:0] OFS_IDENT_FIVE   = 12'hfd4;
	localparam logic [11:0] OFS_IDENT_SIX    = 12'hfd8;
	localparam logic [11:0] OFS_IDENT_SEVEN  = 12'hfdc;
	localparam logic [11:0] OFS_IDENT_ZERO   = 12'hfe0;
	localparam int          ADDR_BITS        = 12;
	localparam int          INFO_BANK1_BIT   = 31;
	localparam int          INFO_BANK0_BIT   = 30;
	localparam int          INFO_OFS_HI      = 10;
	localparam int          INFO_OFS_LO      = 2;
	localparam int          TIMEOUT_LSB      = 8;
	localparam int          EXT_CLK_BIT      = 6;
	localparam int          ONE_CYCLE_BIT    = 5;
	localparam int          SIZE_CODE_LSB    = 4;
	localparam logic [7:0]  TIMEOUT_RST      = 8'h20;
	localparam logic [4:0]  LOG2_SIZE_RST    = 5'h11;
	localparam logic [5:0]  READ_COUNT_RST   = 6'h3f;
	localparam logic [3:0]  SIZE_CODE_8K     = 4'h1;
	localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;

	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} fcap_apb_req_s;

	typedef struct packed {
		logic        ready;
		logic        slvErr;
		logic [31:0] rdata;
	} fcap_apb_rsp_s;
endpackage : fcap_pkg

/* fcap_regs.sv */
// apb register slice: target address, write word, fuses, params, ident
// Summary of operation
// - target address is word aligned, low two bits always read zero
// - unmapped target address write gives slave error, register unchanged
// - bit 31 bank1 info page, bit 30 bank0, bits 10:2 offset
// - 32-bit read-write write word register, reset zero
// - 32-bit read-only fuse word, bit n is fuse n, zero after reset
// - four parameter registers read-only, fixed by integrator parameters
// - row-write timeout in bits 15:8, default 0x20
// - bit 5 reports single-cycle read allowed, default zero
// - bits 4:0 report log2 of flash bytes, default 0x11
// - clock count defaults register, read count default 0x3f
// - program timing defaults packed in four bytes
// - erase timing defaults packed in four bytes
// - ident word four: size code 0x1 in 7:4, continuation in 3:0
// - ident words five to seven read zero
// - ident word zero: low part number byte, upper bits zero
// - without external clock, timer clock source select held zero
// - single-cycle read setting allowed only when parameter set
`timescale 1ns/1ns
module fcap_regs
	import fcap_pkg::*;
#(
	parameter logic [7:0] TIMEOUT        = TIMEOUT_RST,
	parameter bit         EXT_CLK_EN     = 1'b0,
	parameter bit         ONE_CYCLE_RD   = 1'b0,
	parameter logic [4:0] LOG2_FLASH     = LOG2_SIZE_RST,
	parameter logic [9:0] ERASE_CNT_RST  = 10'h000,
	parameter logic [7:0] WRITE_CNT_RST  = 8'h00,
	parameter logic [5:0] READ_CNT_RST   = READ_COUNT_RST,
	parameter logic [7:0] STORE_HOLD     = 8'h00,
	parameter logic [7:0] PROG_TIME      = 8'h00,
	parameter logic [7:0] STROBE_PROG    = 8'h00,
	parameter logic [7:0] PROG_STROBE    = 8'h00,
	parameter logic [7:0] MASS_ERASE     = 8'h00,
	parameter logic [7:0] PAGE_ERASE     = 8'h00,
	parameter logic [7:0] RECOVERY       = 8'h00,
	parameter logic [7:0] SEC_HOLD       = 8'h00,
	// arbitrary neutral identity values
	parameter logic [3:0] CONT_CODE      = 4'h0,
	parameter logic [7:0] PART_LOW       = 8'h00,
	parameter int         INFO_WORDS     = 512
) (
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	input  wire fcap_apb_req_s apbReq,
	input  wire logic [31:0]   fuseIn,
	input  wire logic [1:0]    timerClkSrcReq,
	input  wire logic [5:0]    readClkConfReq,
	output fcap_apb_rsp_s      apbRsp,
	output logic [31:0]        targetAddr,
	output logic [31:0]        writeWord,
	output logic [1:0]         timerClkSrc,
	output logic [5:0]         readClkConf
);
	localparam logic [31:0] FLASH_BYTES = 32'(64'd1 << LOG2_FLASH);

	initial begin
		if (LOG2_FLASH < 5'd3 || LOG2_FLASH > 5'd30)
			$error("LOG2_FLASH out of range");
		if (INFO_WORDS < 1 || INFO_WORDS > 512)
			$error("INFO_WORDS out of range");
	end

	logic        access;
	logic        wrAccess;
	logic        addrOk;
	logic [31:0] wordIn;
	logic [31:0] rdMux;
	logic [31:0] paramWord0;
	logic [31:0] paramWord1;
	logic [31:0] paramWord2;
	logic [31:0] paramWord3;
	logic [31:0] fuse_q;
	logic        rdSetup;

	assign access   = apbReq.sel && apbReq.enable;
	assign wrAccess = access && apbReq.write;
	assign wordIn   = {apbReq.wdata[31:2], 2'b00};
	assign rdSetup  = apbReq.sel && !apbReq.enable && !apbReq.write;

	always_comb begin
		addrOk = 1'b0;
		if (wordIn[INFO_BANK1_BIT] || wordIn[INFO_BANK0_BIT])
			addrOk = !(wordIn[INFO_BANK1_BIT] && wordIn[INFO_BANK0_BIT])
				&& wordIn[29:INFO_OFS_HI+1] == '0
				&& 32'(wordIn[INFO_OFS_HI:INFO_OFS_LO]) < 32'(INFO_WORDS);
		else
			addrOk = wordIn < FLASH_BYTES;
	end

	assign paramWord0 = {16'h0000, TIMEOUT, 1'b0, EXT_CLK_EN, ONE_CYCLE_RD,
		LOG2_FLASH};
	assign paramWord1 = {8'h00, ERASE_CNT_RST, WRITE_CNT_RST, READ_CNT_RST};
	assign paramWord2 = {STORE_HOLD, PROG_TIME, STROBE_PROG, PROG_STROBE};
	assign paramWord3 = {MASS_ERASE, PAGE_ERASE, RECOVERY, SEC_HOLD};

	// target address update
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			targetAddr <= WORD_ZERO;
		else if (wrAccess && apbReq.addr == OFS_TARGET_ADDR && addrOk)
			targetAddr <= wordIn;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			writeWord <= WORD_ZERO;
		else if (wrAccess && apbReq.addr == OFS_WRITE_WORD)
			writeWord <= apbReq.wdata;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			fuse_q <= WORD_ZERO;
		else
			fuse_q <= fuseIn;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			timerClkSrc <= 2'b00;
			readClkConf <= READ_CNT_RST;
		end else begin
			timerClkSrc <= EXT_CLK_EN ? timerClkSrcReq : 2'b00;
			if (readClkConfReq != 6'h01 || ONE_CYCLE_RD)
				readClkConf <= readClkConfReq;
		end
	end

	// read mux
	always_comb begin
		unique case (apbReq.addr)
			OFS_TARGET_ADDR:  rdMux = targetAddr;
			OFS_WRITE_WORD:   rdMux = writeWord;
			OFS_FUSE_BITS:    rdMux = fuse_q;
			OFS_TIMEOUT_OPTS: rdMux = paramWord0;
			OFS_CLK_DEFAULTS: rdMux = paramWord1;
			OFS_PROG_TIMING:  rdMux = paramWord2;
			OFS_ERASE_TIMING: rdMux = paramWord3;
			OFS_IDENT_FOUR:   rdMux = {24'h0, SIZE_CODE_8K, CONT_CODE};
			OFS_IDENT_FIVE,
			OFS_IDENT_SIX,
			OFS_IDENT_SEVEN:  rdMux = WORD_ZERO;
			OFS_IDENT_ZERO:   rdMux = {24'h0, PART_LOW};
			default:          rdMux = WORD_ZERO;
		endcase
	end

	// response registers, one-cycle setup then ready
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			apbRsp <= '0;
		end else begin
			apbRsp.ready  <= apbReq.sel && !apbReq.enable;
			apbRsp.rdata  <= apbReq.write ? WORD_ZERO : rdMux;
			apbRsp.slvErr <= apbReq.sel && !apbReq.enable && apbReq.write
				&& apbReq.addr == OFS_TARGET_ADDR && !addrOk;
		end
	end

	// read-only untouched: no write path exists to those words

	targ_aligned_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		targetAddr[1:0] == 2'b00)
		else $error("target address unaligned");
	addr_store_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		wrAccess && apbReq.addr == OFS_TARGET_ADDR && addrOk
		|=> targetAddr == $past(wordIn))
		else $error("target address not stored");

	err_keeps_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		apbRsp.slvErr |=> $stable(targetAddr))
		else $error("target address changed on error");
	err_raise_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		apbReq.sel && !apbReq.enable && apbReq.write && !addrOk
		&& apbReq.addr == OFS_TARGET_ADDR |=> apbRsp.slvErr)
		else $error("missing error on unmapped address");
	addr_hold_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!(wrAccess && apbReq.addr == OFS_TARGET_ADDR && addrOk)
		|=> $stable(targetAddr))
		else $error("target address changed without write");
	err_only_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		apbRsp.slvErr |-> $past(apbReq.addr) == OFS_TARGET_ADDR
		&& $past(apbReq.write))
		else $error("error on other register");

	both_banks_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		wordIn[INFO_BANK1_BIT] && wordIn[INFO_BANK0_BIT] |-> !addrOk)
		else $error("both info banks accepted");
	info_ofs_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		wrAccess && apbReq.addr == OFS_TARGET_ADDR && addrOk
		&& (wordIn[INFO_BANK1_BIT] || wordIn[INFO_BANK0_BIT])
		|=> targetAddr[INFO_OFS_HI:INFO_OFS_LO]
		== $past(wordIn[INFO_OFS_HI:INFO_OFS_LO]))
		else $error("info page offset not stored");

	word_store_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		wrAccess && apbReq.addr == OFS_WRITE_WORD
		|=> writeWord == $past(apbReq.wdata))
		else $error("write word not stored");
	word_hold_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!(wrAccess && apbReq.addr == OFS_WRITE_WORD)
		|=> $stable(writeWord))
		else $error("write word changed without write");
	fuse_follow_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		##1 fuse_q == $past(fuseIn))
		else $error("fuse word stale");
	fuse_read_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_FUSE_BITS
		|=> apbRsp.rdata == $past(fuse_q))
		else $error("fuse word read wrong");

	param_read_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_TIMEOUT_OPTS
		|=> apbRsp.rdata[15:8] == TIMEOUT)
		else $error("timeout field wrong");
	ext_clk_bit_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_TIMEOUT_OPTS
		|=> apbRsp.rdata[EXT_CLK_BIT] == EXT_CLK_EN)
		else $error("external clock bit wrong");
	one_cycle_bit_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_TIMEOUT_OPTS
		|=> apbRsp.rdata[ONE_CYCLE_BIT] == ONE_CYCLE_RD)
		else $error("single-cycle read bit wrong");
	flash_size_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_TIMEOUT_OPTS
		|=> apbRsp.rdata[4:0] == LOG2_FLASH
		&& apbRsp.rdata[31:16] == 16'h0000 && !apbRsp.rdata[7])
		else $error("flash size field wrong");
	clk_counts_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_CLK_DEFAULTS
		|=> apbRsp.rdata[5:0] == READ_CNT_RST
		&& apbRsp.rdata[31:26] == 6'h00)
		else $error("clock count defaults wrong");
	prog_timing_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_PROG_TIMING
		|=> apbRsp.rdata[31:24] == STORE_HOLD
		&& apbRsp.rdata[7:0] == PROG_STROBE)
		else $error("program timing defaults wrong");
	erase_timing_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_ERASE_TIMING
		|=> apbRsp.rdata[31:24] == MASS_ERASE
		&& apbRsp.rdata[15:8] == RECOVERY)
		else $error("erase timing defaults wrong");

	ident_four_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_IDENT_FOUR
		|=> apbRsp.rdata == {24'h0, SIZE_CODE_8K, CONT_CODE})
		else $error("ident word four wrong");
	ident_zero_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		apbReq.sel && !apbReq.enable && (apbReq.addr == OFS_IDENT_FIVE
		|| apbReq.addr == OFS_IDENT_SIX || apbReq.addr == OFS_IDENT_SEVEN)
		|=> apbRsp.rdata == WORD_ZERO)
		else $error("reserved ident nonzero");
	ident_part_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		rdSetup && apbReq.addr == OFS_IDENT_ZERO
		|=> apbRsp.rdata == {24'h0, PART_LOW})
		else $error("ident word zero wrong");

	clk_src_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!EXT_CLK_EN |-> timerClkSrc == 2'b00)
		else $error("timer clock source not zero");
	one_cycle_a: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!ONE_CYCLE_RD |-> readClkConf != 6'h01)
		else $error("single-cycle read set illegally");

	addr_ok_c: cover property (@(posedge core_clk) disable iff (!rst_b)
		wrAccess && apbReq.addr == OFS_TARGET_ADDR && addrOk);
	addr_err_c: cover property (@(posedge core_clk) disable iff (!rst_b)
		apbRsp.slvErr);
	info_page_c: cover property (@(posedge core_clk) disable iff (!rst_b)
		targetAddr[INFO_BANK1_BIT]);
	info_bank0_c: cover property (@(posedge core_clk) disable iff (!rst_b)
		targetAddr[INFO_BANK0_BIT]);
	one_cycle_req_c: cover property (@(posedge core_clk) disable iff (!rst_b)
		readClkConfReq == 6'h01);
endmodule : fcap_regs

/* fcap_apb_host.sv */
// apb master model driving the fcap register slice
`timescale 1ns/1ns
module fcap_apb_host
	import fcap_pkg::*;
(
	input  wire logic          core_clk,
	input  wire fcap_apb_rsp_s apbRsp,
	output fcap_apb_req_s      apbReq
);
	initial apbReq = '0;
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge core_clk) #1;
		apbReq = '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk) #1;
		apbReq.enable = 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (apbRsp.ready !== 1'b1 && n < 8);
		rd = apbRsp.rdata;
		er = apbRsp.slvErr;
		if (n != 1)
			er = 1'bx;
		#1 apbReq = '{1'b0, 1'b0, ~w, ~a, ~d};
	endtask : xfer
endmodule : fcap_apb_host

/* fcap_regs_tb.sv */
// self-checking bench for the fcap register slice
`timescale 1ns/1ns
module fcap_regs_tb
	import fcap_pkg::*;
;
	logic          core_clk = 1'b0;
	logic          rst_b = 1'b0;
	logic [31:0]   fuseIn = 32'h0;
	logic [1:0]    timerClkSrcReq = 2'h0;
	logic [5:0]    readClkConfReq = 6'h0;
	fcap_apb_req_s apbReq;
	fcap_apb_rsp_s apbRsp;
	logic [31:0]   targetAddr, writeWord, rd, expAddr, expWord, a, d;
	logic [1:0]    timerClkSrc;
	logic [5:0]    readClkConf, expConf;
	logic          er;
	int            mismatches = 0, n_checks = 0, seed = 87936, cycles = 0;
	localparam logic [11:0] OFS [13] = '{OFS_TARGET_ADDR, OFS_WRITE_WORD,
		OFS_FUSE_BITS, OFS_TIMEOUT_OPTS, OFS_CLK_DEFAULTS, OFS_PROG_TIMING,
		OFS_ERASE_TIMING, OFS_IDENT_FOUR, OFS_IDENT_FIVE, OFS_IDENT_SIX,
		OFS_IDENT_SEVEN, OFS_IDENT_ZERO, 12'h100};

	always #10 core_clk = ~core_clk;

	// identity values 4'h9 and 8'h5c are arbitrary
	fcap_regs #(.PROG_TIME(8'h22), .PAGE_ERASE(8'h66), .SEC_HOLD(8'h88),
		.CONT_CODE(4'h9), .PART_LOW(8'h5c))
		u_fcap_regs (.core_clk(core_clk), .rst_b(rst_b),
		.apbReq(apbReq), .fuseIn(fuseIn), .timerClkSrcReq(timerClkSrcReq),
		.readClkConfReq(readClkConfReq), .apbRsp(apbRsp),
		.targetAddr(targetAddr), .writeWord(writeWord),
		.timerClkSrc(timerClkSrc), .readClkConf(readClkConf));

	fcap_apb_host u_fcap_apb_host (.core_clk(core_clk), .apbRsp(apbRsp),
		.apbReq(apbReq));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic results;
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	function automatic bit ok(logic [31:0] x);
		if (x[31] ^ x[30])
			return x[29:11] == 19'h0;
		return x < (32'h1 << LOG2_SIZE_RST);
	endfunction : ok

	function automatic logic [31:0] expRead(logic [11:0] o);
		case (o)
			OFS_TARGET_ADDR:  return expAddr;
			OFS_WRITE_WORD:   return expWord;
			OFS_FUSE_BITS:    return fuseIn;
			OFS_TIMEOUT_OPTS: return {16'h0, TIMEOUT_RST, 3'h0, LOG2_SIZE_RST};
			OFS_CLK_DEFAULTS: return {26'h0, READ_COUNT_RST};
			OFS_PROG_TIMING:  return 32'h0022_0000;
			OFS_ERASE_TIMING: return 32'h0066_0088;
			OFS_IDENT_FOUR:   return {24'h0, SIZE_CODE_8K, 4'h9};
			OFS_IDENT_ZERO:   return 32'h0000_005c;
			default:          return WORD_ZERO;
		endcase
	endfunction : expRead

	task automatic rdall;
		foreach (OFS[i]) begin
			u_fcap_apb_host.xfer(1'b0, OFS[i], 32'h0, rd, er);
			chk(rd, expRead(OFS[i]));
			chk({31'h0, er}, 32'h0);
		end
	endtask : rdall

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			results();
		end
		expConf <= !rst_b ? READ_COUNT_RST :
			(readClkConfReq == 6'h01 ? expConf : readClkConfReq);
		#1 readClkConfReq = ($random(seed) & 1) ? 6'h01 : 6'($random(seed));
		timerClkSrcReq = 2'($random(seed));
	end

	always @(negedge core_clk) if (cycles > 1) begin
		chk({26'h0, readClkConf}, {26'h0, expConf});
		chk({30'h0, timerClkSrc}, 32'h0);
	end

	initial begin
		expAddr = 32'h0;
		expWord = 32'h0;
		repeat (12) @(posedge core_clk);
		#1 rst_b = 1'b1;
		rdall();
		repeat (20) begin
			d = $random(seed);
			case ($random(seed) & 7)
				0: a = d & 32'h0001_ffff;
				1: a = {2'b10, 19'h0, d[10:0]};
				2: a = {2'b01, 19'h0, d[10:0]};
				3: a = 32'h0001_ffff;
				4: a = 32'h0002_0000;
				5: a = {2'b11, 19'h0, d[10:0]};
				default: a = d;
			endcase
			u_fcap_apb_host.xfer(1'b1, OFS_TARGET_ADDR, a, rd, er);
			chk({31'h0, er}, {31'h0, !ok(a)});
			if (ok(a))
				expAddr = {a[31:2], 2'b00};
			chk(targetAddr, expAddr);
			u_fcap_apb_host.xfer(1'b1, OFS_WRITE_WORD, d, rd, er);
			expWord = d;
			chk(writeWord, expWord);
			fuseIn = $random(seed);
			foreach (OFS[i]) if (i > 1) begin
				u_fcap_apb_host.xfer(1'b1, OFS[i], $random(seed), rd, er);
				chk({31'h0, er}, 32'h0);
			end
			rdall();
		end
		results();
	end
endmodule : fcap_regs_tb
